// ---- power_wake_pkg.sv ----
// Package of register map, field positions and timing constants for the power wake control block
package power_wake_pkg;

  localparam logic [7:0] power_control_addr    = 8'h40;
  localparam logic [7:0] wake_enable_addr      = 8'h41;
  localparam logic [7:0] wake_status_addr      = 8'h42;
  localparam logic [7:0] wake_weekday_addr     = 8'h43;
  localparam logic [7:0] wake_date_addr        = 8'h44;
  localparam logic [7:0] wake_month_addr       = 8'h45;
  localparam logic [7:0] wake_year_addr        = 8'h46;
  localparam logic [7:0] ram_lock_control_addr = 8'h47;
  localparam logic [7:0] wake_century_addr     = 8'h48;
  localparam logic [7:0] tick_ctrl_addr        = 8'h49;
  localparam logic [7:0] supply_ctrl_addr      = 8'h4A;

  localparam int pc_soft_off_bit  = 5;
  localparam int pc_power_off_bit = 7;
  localparam int we_time_bit      = 0;
  localparam int we_train_bit     = 2;
  localparam int we_ring_bit      = 3;
  localparam int ws_time_bit      = 0;
  localparam int ws_ring_bit      = 1;
  localparam int ws_pin_bit       = 7;
  localparam int rl_upper_bit     = 3;
  localparam int rl_lowrd_bit     = 4;
  localparam int rl_lowwr_bit     = 5;
  localparam int rl_maskwr_bit    = 6;
  localparam int rl_window_bit    = 7;
  localparam logic [7:0] rl_used_mask    = 8'hF8;
  localparam logic [7:0] we_used_mask    = 8'h0D;
  localparam logic [7:0] zero_byte       = 8'h00;
  localparam logic [7:0] blocked_byte    = 8'hFF;

  // RAM address windows
  localparam logic [7:0] gp_lo_start     = 8'h0E;
  localparam logic [7:0] gp_lo_end       = 8'h3F;
  localparam logic [7:0] bank0_hi_start  = 8'h40;
  localparam logic [7:0] bank0_hi_end    = 8'h7F;
  localparam logic [7:0] window_start    = 8'h38;
  localparam logic [7:0] window_end      = 8'h3F;
  localparam logic [6:0] upper_low_end   = 7'h1F;

  // Timekeeping clock figures
  localparam int tk_clock_hz      = 32768;
  localparam int holdoff_ms       = 1000;
  localparam int slot_us          = 62500;
  // Multiply before dividing so that fractions of a second, such as the slot, give whole clock periods
  localparam int holdoff_ticks    = tk_clock_hz * holdoff_ms / 1000;
  localparam int slot_ticks       = tk_clock_hz * slot_us / 1000000;
  localparam int train_slots      = 3;

  typedef enum logic [1:0] {
    pw_off     = 2'b00,
    pw_holdoff = 2'b01,
    pw_on      = 2'b11
  } power_state_type;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] weekday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] century;
  } calendar_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] bank;
    logic [7:0] addr;
    logic       upper;
  } ram_access_type;

endpackage : power_wake_pkg

// ---- power_wake_control.sv ----
// Power wake control: wake and shutdown requests, event status and RAM locks
//
// Operation
// - Hold off wake requests one second after restore
// - Wake and shutdown requests are high pulses
// - Enabled calendar match pulses wake request
// - Enabled ring event pulses wake request
// - Single ring falling edge is an event
// - Train: edges in three slots after quiet
// - Soft off write pulses shutdown, reads zero
// - Power off flag sets on backup, W1C
// - Ring masked in power off plus one second
// - Backup calendar match remembered until holdoff ends
// - Pre-off events wake unless soft off came
// - Eight calendar fields compared against live clock
// - Registers ignore system reset, cleared first power except lock bits
// - Status read clears event bits
// - Match status sets regardless of enable
// - Ring status sets regardless of enable
// - Status bit seven shows debounced ring pin level, one while masked
// - Lock bits set only, cleared by master reset
// - Upper lock blocks upper data port
// - Low upper bytes read and write blocks
// - Mask all writes over listed RAM
// - Window lock blocks 38h-3Fh in every bank on the lower port, not the upper port
`timescale 1ns/100ps
module power_wake_control
  import power_wake_pkg::*;
#(
  parameter int holdoff_count = holdoff_ticks,
  parameter int slot_count    = slot_ticks
) (
  // Clock, enable and resets
  input  wire logic           ref_clk,
  input  wire logic           reset,
  input  wire logic           clk_en,
  input  wire logic           first_power,
  input  wire logic           hardware_master_reset,
  // Register port
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [7:0]          reg_rdata,
  // Timekeeping
  input  wire logic           tk_tick,
  input  wire calendar_type   live_time,
  input  wire logic [23:0]    alarm_time,
  input  wire logic           main_supply_ok,
  input  wire logic           ring_n,
  // RAM access checks
  input  wire ram_access_type ram_req,
  output logic                ram_wr_allow_q,
  output logic                ram_rd_block_q,
  // Requests
  output logic                wake_request_irq,
  output logic                shutdown_request_irq
);

  localparam int hw = $clog2(holdoff_count + 1);
  localparam int sw = $clog2(slot_count + 1);

  logic [7:0]      wake_enable_q;
  logic            power_off_flag_q;
  logic [1:0]      wake_status_q;
  logic [7:0]      ram_lock_q;
  logic [31:0]     wake_date_q;
  logic [7:0]      wake_century_q;
  logic [7:0]      rdata_q;
  logic            wake_irq_q;
  logic            shut_irq_q;
  logic [2:0]      ring_sync_q;
  logic            ring_stable_q;
  power_state_type state_q;
  logic [hw-1:0]   holdoff_cnt_q;
  logic [sw-1:0]   slot_cnt_q;
  logic            slot_edge_q;
  logic [1:0]      run_q;
  logic            quiet_seen_q;
  logic            match_q;
  logic            pend_q;
  logic            soft_off_seen_q;

  logic en_tick;
  logic fall;
  logic ring_masked;
  logic ring_event;
  logic match_now;
  logic match_rise;
  logic wr_soft_off;
  logic rd_status;
  logic slot_end;
  logic enter_off;

  assign en_tick     = clk_en & tk_tick;
  assign ring_masked = (state_q != pw_on);
  // Second and third stages must agree, so single-stage glitches never count
  assign fall = en_tick & ~ring_masked & (ring_sync_q[1] == ring_sync_q[2]) &
                ring_stable_q & ~ring_sync_q[2];
  assign slot_end = en_tick & (slot_cnt_q == sw'(slot_count - 1));
  assign match_now = (live_time == {alarm_time, wake_date_q, wake_century_q});
  assign match_rise = en_tick & match_now & ~match_q;
  assign ring_event = wake_enable_q[we_train_bit] ?
                      (slot_end & (slot_edge_q | fall) & quiet_seen_q & (run_q == 2'(train_slots - 1)))
                    : fall;
  assign wr_soft_off = clk_en & reg_wr & (reg_addr == power_control_addr) & reg_wdata[pc_soft_off_bit];
  assign rd_status   = clk_en & reg_rd & (reg_addr == wake_status_addr);
  assign enter_off   = clk_en & (state_q != pw_off) & ~main_supply_ok;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Ring synchroniser, stepped by the timekeeping tick so that every edge meets a tick
  always_ff @(posedge ref_clk) begin
    if (first_power) begin
      ring_sync_q   <= '1;
      ring_stable_q <= 1'b1;
    end else if (clk_en) begin
      if (en_tick) begin
        ring_sync_q <= {ring_sync_q[1:0], ring_n};
        if (ring_sync_q[1] == ring_sync_q[2]) begin
          ring_stable_q <= ring_sync_q[2];
        end
      end
      if (ring_masked) begin
        ring_stable_q <= 1'b1;
      end
    end
  end

  // Supply state and holdoff; power-domain registers ignore system reset
  always_ff @(posedge ref_clk) begin
    if (first_power) begin
      state_q       <= pw_on;
      holdoff_cnt_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        pw_off: begin
          if (main_supply_ok) begin
            state_q       <= pw_holdoff;
            holdoff_cnt_q <= '0;
          end
        end
        pw_holdoff: begin
          if (!main_supply_ok) begin
            state_q <= pw_off;
          end else if (en_tick) begin
            if (holdoff_cnt_q == hw'(holdoff_count - 1)) begin
              state_q <= pw_on;
            end else begin
              holdoff_cnt_q <= holdoff_cnt_q + 1'b1;
            end
          end
        end
        pw_on: begin
          if (!main_supply_ok) begin
            state_q <= pw_off;
          end
        end
        default: begin
          state_q <= pw_off;
        end
      endcase
    end
  end

  // Train slot timing
  always_ff @(posedge ref_clk) begin
    if (first_power || ring_masked) begin
      slot_cnt_q   <= '0;
      slot_edge_q  <= 1'b0;
      run_q        <= '0;
      quiet_seen_q <= 1'b0;
    end else if (en_tick) begin
      slot_cnt_q <= slot_end ? '0 : slot_cnt_q + 1'b1;
      if (slot_end) begin
        slot_edge_q <= 1'b0;
        if (slot_edge_q | fall) begin
          run_q <= (run_q == 2'(train_slots - 1)) ? run_q : run_q + 1'b1;
          if (run_q == 2'(train_slots - 1)) begin
            quiet_seen_q <= 1'b0;
          end
        end else begin
          run_q        <= '0;
          quiet_seen_q <= 1'b1;
        end
      end else if (fall) begin
        slot_edge_q <= 1'b1;
      end
    end
  end

  // Registers and events
  always_ff @(posedge ref_clk) begin
    if (first_power) begin
      wake_enable_q    <= zero_byte;
      power_off_flag_q <= 1'b0;
      wake_status_q    <= '0;
      wake_date_q      <= '0;
      wake_century_q   <= zero_byte;
      match_q          <= 1'b0;
      pend_q           <= 1'b0;
      soft_off_seen_q  <= 1'b0;
    end else if (clk_en) begin
      if (en_tick) begin
        match_q <= match_now;
      end
      if (reg_wr) begin
        case (reg_addr)
          power_control_addr: begin
            if (reg_wdata[pc_power_off_bit]) begin
              power_off_flag_q <= 1'b0;
            end
          end
          wake_enable_addr:  wake_enable_q <= reg_wdata & we_used_mask;
          wake_weekday_addr: wake_date_q[31:24] <= reg_wdata;
          wake_date_addr:    wake_date_q[23:16] <= reg_wdata;
          wake_month_addr:   wake_date_q[15:8] <= reg_wdata;
          wake_year_addr:    wake_date_q[7:0] <= reg_wdata;
          wake_century_addr: wake_century_q <= reg_wdata;
          default: begin
          end
        endcase
      end
      if (rd_status) begin
        wake_status_q <= '0;
      end
      // Set wins over the read clear
      if (match_rise) begin
        wake_status_q[ws_time_bit] <= 1'b1;
      end
      if (ring_event) begin
        wake_status_q[ws_ring_bit] <= 1'b1;
      end
      if (wr_soft_off) begin
        soft_off_seen_q <= 1'b1;
      end
      if (enter_off) begin
        power_off_flag_q <= 1'b1;
        // Pending events are kept only when shutdown was not software driven
        pend_q <= ~soft_off_seen_q & (wake_status_q[ws_time_bit] & wake_enable_q[we_time_bit] |
                  wake_status_q[ws_ring_bit] & wake_enable_q[we_ring_bit]);
        soft_off_seen_q <= 1'b0;
      end else if (state_q != pw_on && match_rise && wake_enable_q[we_time_bit]) begin
        pend_q <= 1'b1;
      end else if (state_q == pw_on) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Request pulses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_irq_q <= 1'b0;
      shut_irq_q <= 1'b0;
    end else if (clk_en) begin
      wake_irq_q <= (state_q == pw_on) & (pend_q | (match_rise & wake_enable_q[we_time_bit]) |
                    (ring_event & wake_enable_q[we_ring_bit])) & ~wake_irq_q;
      shut_irq_q <= wr_soft_off;
    end
  end

  // Lock bits only set; master reset alone clears them
  always_ff @(posedge ref_clk) begin
    if (hardware_master_reset) begin
      ram_lock_q <= zero_byte;
    end else if (clk_en && reg_wr && reg_addr == ram_lock_control_addr) begin
      ram_lock_q <= ram_lock_q | (reg_wdata & rl_used_mask);
    end
  end

  // RAM access gating, registered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ram_wr_allow_q <= 1'b0;
      ram_rd_block_q <= 1'b0;
    end else if (clk_en) begin
      if (ram_req.upper) begin
        ram_wr_allow_q <= ram_req.wr & ~ram_lock_q[rl_upper_bit] & ~ram_lock_q[rl_maskwr_bit] &
                          ~(ram_lock_q[rl_lowwr_bit] & (ram_req.addr[6:0] <= upper_low_end));
        ram_rd_block_q <= ram_req.rd & (ram_lock_q[rl_upper_bit] |
                          (ram_lock_q[rl_lowrd_bit] & (ram_req.addr[6:0] <= upper_low_end)));
      end else begin
        ram_wr_allow_q <= ram_req.wr &
          ~(ram_lock_q[rl_window_bit] & in_range(ram_req.addr, window_start, window_end)) &
          ~(ram_lock_q[rl_maskwr_bit] & (in_range(ram_req.addr, gp_lo_start, gp_lo_end) |
            (ram_req.bank == 2'b00 && in_range(ram_req.addr, bank0_hi_start, bank0_hi_end))));
        ram_rd_block_q <= ram_req.rd & ram_lock_q[rl_window_bit] &
                          in_range(ram_req.addr, window_start, window_end);
      end
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= zero_byte;
    end else if (clk_en) begin
      rdata_q <= zero_byte;
      if (reg_rd) begin
        case (reg_addr)
          power_control_addr:    rdata_q <= {power_off_flag_q, 7'h00};
          wake_enable_addr:      rdata_q <= wake_enable_q;
          wake_status_addr:      rdata_q <= {ring_stable_q, 5'h00, wake_status_q};
          wake_weekday_addr:     rdata_q <= wake_date_q[31:24];
          wake_date_addr:        rdata_q <= wake_date_q[23:16];
          wake_month_addr:       rdata_q <= wake_date_q[15:8];
          wake_year_addr:        rdata_q <= wake_date_q[7:0];
          ram_lock_control_addr: rdata_q <= ram_lock_q;
          wake_century_addr:     rdata_q <= wake_century_q;
          default:               rdata_q <= zero_byte;
        endcase
      end
    end
  end

  assign reg_rdata            = rdata_q;
  assign wake_request_irq     = wake_irq_q;
  assign shutdown_request_irq = shut_irq_q;

endmodule : power_wake_control

// ---- power_wake_asserts.sv ----
// Checker for the power wake control ports
`timescale 1ns/100ps
module power_wake_asserts
  import power_wake_pkg::*;
#(
  parameter int holdoff_count = holdoff_ticks
) (
  // Clock and resets
  input wire logic           ref_clk,
  input wire logic           reset,
  input wire logic           first_power,
  input wire logic           hardware_master_reset,
  // Register port
  input wire logic [7:0]     reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [7:0]     reg_rdata,
  // Supply, tick and RAM
  input wire logic           tk_tick,
  input wire logic           main_supply_ok,
  input wire ram_access_type ram_req,
  input wire logic           ram_wr_allow_q,
  input wire logic           ram_rd_block_q,
  // Requests
  input wire logic           wake_request_irq,
  input wire logic           shutdown_request_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic lock_q;
  int   hold_q;
  wire  soft_wr = reg_wr && reg_addr == power_control_addr && reg_wdata[pc_soft_off_bit];
  wire  in_win = !ram_req.upper && ram_req.addr >= window_start && ram_req.addr <= window_end;
  // Mirror of the window lock; software has no way to clear it
  always_ff @(posedge ref_clk) begin
    if (hardware_master_reset || first_power) lock_q <= 1'b0;
    else if (reg_wr && reg_addr == ram_lock_control_addr && reg_wdata[rl_window_bit]) lock_q <= 1'b1;
  end
  // Ticks since main supply returned; one tick of slack for the registered pulse
  always_ff @(posedge ref_clk) begin
    if (first_power) hold_q <= holdoff_count;
    else if (!main_supply_ok) hold_q <= 0;
    else if (tk_tick && hold_q < holdoff_count) hold_q <= hold_q + 1;
  end
  sequence off_pulse;
    shutdown_request_irq ##1 !shutdown_request_irq;
  endsequence
  soft_off_a: assert property (soft_wr |=> off_pulse)
    else $error("no shutdown pulse after soft off");
  shut_cause_a: assert property (shutdown_request_irq |-> $past(soft_wr))
    else $error("shutdown pulse without soft off");
  wake_pulse_a: assert property (wake_request_irq |=> !wake_request_irq)
    else $error("wake request longer than one cycle");
  soft_zero_a: assert property (reg_rd && reg_addr == power_control_addr |=> !reg_rdata[pc_soft_off_bit])
    else $error("soft off bit reads one");
  off_quiet_a: assert property (!main_supply_ok && !$past(main_supply_ok) |-> !wake_request_irq)
    else $error("wake request while on backup");
  holdoff_a: assert property (main_supply_ok && hold_q < holdoff_count - 1 |-> !wake_request_irq)
    else $error("wake request inside holdoff");
  win_rd_a: assert property (lock_q && in_win && ram_req.rd |=> ram_rd_block_q)
    else $error("locked window read not blocked");
  win_wr_a: assert property (lock_q && in_win && ram_req.wr |=> !ram_wr_allow_q)
    else $error("locked window write allowed");
endmodule : power_wake_asserts

bind power_wake_control power_wake_asserts #(.holdoff_count(holdoff_count)) chk (
  .ref_clk(ref_clk), .reset(reset), .first_power(first_power),
  .hardware_master_reset(hardware_master_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tk_tick(tk_tick),
  .main_supply_ok(main_supply_ok), .ram_req(ram_req), .ram_wr_allow_q(ram_wr_allow_q),
  .ram_rd_block_q(ram_rd_block_q), .wake_request_irq(wake_request_irq),
  .shutdown_request_irq(shutdown_request_irq)
);

// ---- wake_unit_model.sv ----
// Wake-up unit model that counts request pulses
`timescale 1ns/100ps
module wake_unit_model (
  // Clock
  input  wire logic ref_clk,
  // Requests
  input  wire logic wake_in,
  input  wire logic shut_in,
  // Counts
  output int        wake_cnt,
  output int        shut_cnt
);
  int wake_q = 0;
  int shut_q = 0;
  // Counting high cycles, not edges, so a stuck request shows as extra pulses
  always @(posedge ref_clk) begin
    if (wake_in === 1'b1) wake_q <= wake_q + 1;
    if (shut_in === 1'b1) shut_q <= shut_q + 1;
  end
  assign wake_cnt = wake_q;
  assign shut_cnt = shut_q;
endmodule : wake_unit_model

// ---- tb_top.sv ----
// Testbench for the power wake control block
`timescale 1ns/100ps
module tb_top;
  import power_wake_pkg::*;
  localparam int           hold_n = 4;
  localparam calendar_type cal = {8'h30, 8'h15, 8'h07, 8'h03, 8'h12, 8'h05, 8'h24, 8'h20};
  logic           ref_clk = 1'b0;
  logic           reset = 1'b1;
  logic           first_power = 1'b1;
  logic           hardware_master_reset = 1'b1;
  logic [7:0]     reg_addr = 8'h00;
  logic [7:0]     reg_wdata = 8'h00;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic [7:0]     reg_rdata;
  logic           tk_tick = 1'b0;
  logic [1:0]     tk_cnt = 2'h0;
  calendar_type   live_time = cal ^ 64'h1;
  logic           main_supply_ok = 1'b1;
  logic           ring_n = 1'b1;
  ram_access_type ram_req = '0;
  logic           wr_allow, rd_block, wake_irq, shut_irq;
  int             wake_cnt, shut_cnt, cyc;
  int             n_mismatch = 0;
  int             num_checks = 0;
  logic [7:0]     rd_val;

  always #2 ref_clk = ~ref_clk;
  // Timekeeping tick every four cycles keeps the run short
  always @(posedge ref_clk) begin
    tk_cnt <= tk_cnt + 2'h1;
    tk_tick <= (tk_cnt == 2'h3);
  end

  power_wake_control #(.holdoff_count(hold_n), .slot_count(8)) DUT (
    .ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .first_power(first_power),
    .hardware_master_reset(hardware_master_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tk_tick(tk_tick),
    .live_time(live_time), .alarm_time({cal.sec, cal.min, cal.hour}),
    .main_supply_ok(main_supply_ok), .ring_n(ring_n), .ram_req(ram_req),
    .ram_wr_allow_q(wr_allow), .ram_rd_block_q(rd_block),
    .wake_request_irq(wake_irq), .shutdown_request_irq(shut_irq)
  );
  wake_unit_model MODEL (
    .ref_clk(ref_clk), .wake_in(wake_irq), .shut_in(shut_irq),
    .wake_cnt(wake_cnt), .shut_cnt(shut_cnt)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic ram_chk(input logic w, input logic u, input logic [7:0] a, input logic e);
    @(posedge ref_clk);
    ram_req <= '{w, !w, 2'h0, a, u};
    @(posedge ref_clk);
    ram_req <= '0;
    #1 chk({7'h00, w ? wr_allow : rd_block}, {7'h00, e});
  endtask : ram_chk

  task automatic wait_wake(output int c);
    int start;
    start = wake_cnt;
    c = 0;
    while (wake_cnt == start) begin
      @(posedge ref_clk);
      c++;
      if (c > 200) begin
        n_mismatch++;
        give_verdict();
      end
    end
  endtask : wait_wake

  task automatic t_regs();
    reg_read(power_control_addr, rd_val); chk(rd_val, 8'h00);
    reg_read(wake_enable_addr, rd_val); chk(rd_val, 8'h00);
    reg_read(supply_ctrl_addr, rd_val); chk(rd_val, 8'h00);
    reg_write(wake_enable_addr, 8'hFF);
    @(posedge ref_clk) reset <= 1'b1;
    @(posedge ref_clk) reset <= 1'b0;
    reg_read(wake_enable_addr, rd_val); chk(rd_val, 8'h0D);
    $display("test regs done");
  endtask : t_regs

  task automatic t_soft_off();
    reg_write(power_control_addr, 8'h00);
    reg_write(power_control_addr, 8'h20);
    repeat (2) @(posedge ref_clk);
    chk(8'(shut_cnt), 8'h01);
    reg_read(power_control_addr, rd_val); chk(rd_val, 8'h00);
    $display("test soft off done");
  endtask : t_soft_off

  task automatic t_match();
    reg_write(wake_enable_addr, 8'h00);
    reg_write(wake_weekday_addr, cal.weekday);
    reg_write(wake_date_addr, cal.date);
    reg_write(wake_month_addr, cal.month);
    reg_write(wake_year_addr, cal.year);
    reg_write(wake_century_addr, cal.century);
    @(posedge ref_clk) live_time <= cal;
    repeat (12) @(posedge ref_clk);
    reg_read(wake_status_addr, rd_val); chk(rd_val, 8'h81);
    reg_read(wake_status_addr, rd_val); chk(rd_val, 8'h80);
    chk(8'(wake_cnt), 8'h00);
    @(posedge ref_clk) live_time <= cal ^ 64'h1;
    $display("test match done");
  endtask : t_match

  task automatic t_ring();
    reg_write(wake_enable_addr, 8'h08);
    @(posedge ref_clk) ring_n <= 1'b0;
    wait_wake(cyc);
    reg_read(wake_status_addr, rd_val); chk(rd_val, 8'h02);
    @(posedge ref_clk) ring_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reg_read(wake_status_addr, rd_val); chk(rd_val, 8'h80);
    chk(8'(wake_cnt), 8'h01);
    $display("test ring done");
  endtask : t_ring

  task automatic t_power();
    reg_write(wake_enable_addr, 8'h09);
    @(posedge ref_clk) main_supply_ok <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reg_read(power_control_addr, rd_val); chk(rd_val, 8'h80);
    @(posedge ref_clk) live_time <= cal;
    @(posedge ref_clk) ring_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    @(posedge ref_clk) ring_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    @(posedge ref_clk) main_supply_ok <= 1'b1;
    wait_wake(cyc);
    chk(8'(cyc >= (hold_n - 1) * 4), 8'h01);
    repeat (40) @(posedge ref_clk);
    chk(8'(wake_cnt), 8'h02);
    reg_write(power_control_addr, 8'h00);
    reg_read(power_control_addr, rd_val); chk(rd_val, 8'h80);
    reg_write(power_control_addr, 8'h80);
    reg_read(power_control_addr, rd_val); chk(rd_val, 8'h00);
    $display("test power done");
  endtask : t_power

  task automatic t_train();
    reg_write(wake_enable_addr, 8'h0C);
    @(posedge ref_clk) ring_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    ring_n <= 1'b1;
    repeat (100) @(posedge ref_clk);
    chk(8'(wake_cnt), 8'h02);
    repeat (8) begin
      ring_n <= 1'b0;
      repeat (12) @(posedge ref_clk);
      ring_n <= 1'b1;
      repeat (12) @(posedge ref_clk);
    end
    repeat (40) @(posedge ref_clk);
    chk(8'(wake_cnt), 8'h03);
    main_supply_ok <= 1'b0;
    repeat (4) @(posedge ref_clk);
    main_supply_ok <= 1'b1;
    wait_wake(cyc);
    chk(8'(wake_cnt), 8'h04);
    reg_read(wake_status_addr, rd_val); chk(rd_val & 8'h02, 8'h02);
    $display("test train done");
  endtask : t_train

  task automatic t_lock();
    ram_chk(1'b1, 1'b0, 8'h38, 1'b1);
    reg_write(ram_lock_control_addr, 8'h80);
    reg_write(ram_lock_control_addr, 8'h00);
    ram_chk(1'b1, 1'b0, 8'h38, 1'b0);
    ram_chk(1'b0, 1'b0, 8'h3F, 1'b1);
    ram_chk(1'b1, 1'b0, 8'h37, 1'b1);
    reg_write(ram_lock_control_addr, 8'h30);
    ram_chk(1'b1, 1'b1, 8'h10, 1'b0);
    ram_chk(1'b1, 1'b1, 8'h20, 1'b1);
    ram_chk(1'b0, 1'b1, 8'h10, 1'b1);
    reg_write(ram_lock_control_addr, 8'h08);
    ram_chk(1'b0, 1'b1, 8'h60, 1'b1);
    reg_write(ram_lock_control_addr, 8'h40);
    ram_chk(1'b1, 1'b0, 8'h20, 1'b0);
    ram_chk(1'b1, 1'b0, 8'h0D, 1'b1);
    ram_chk(1'b1, 1'b0, 8'h50, 1'b0);
    $display("test lock done");
  endtask : t_lock

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    hardware_master_reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    first_power <= 1'b0;
    t_regs();
    t_soft_off();
    t_match();
    t_ring();
    t_power();
    t_train();
    t_lock();
    give_verdict();
  end
endmodule : tb_top
